// ---- verilog/ccp_regs.svh ----
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH

// Byte offsets on the register bus
`define CCP_OFF_DUTY_LOW 12'h000
`define CCP_OFF_DUTY_HIGH 12'h004
`define CCP_OFF_CONTROL 12'h008
`define CCP_OFF_PERIOD 12'h00c
`define CCP_OFF_TB_CTRL 12'h010
`define CCP_OFF_CMP_CTRL 12'h014
`define CCP_OFF_STATUS 12'h018
`define CCP_OFF_CMP_COUNT 12'h01c

// Control field positions
`define CCP_MODE_LSB 0
`define CCP_DUTYLO_LSB 4
`define CCP_TB_PRE_LSB 0
`define CCP_TB_ON_BIT 2
`define CCP_TB_POST_LSB 3
`define CCP_CMP_ON_BIT 0
`define CCP_ADC_EN_BIT 1
`define CCP_IRQ_EN_BIT 2
`define CCP_ST_IRQ_BIT 0
`define CCP_ST_POST_BIT 1

// Mode encodings
`define CCP_MODE_SWINT 4'ha
`define CCP_MODE_SPECIAL 4'hb

// Reset values
`define CCP_RST_BYTE 8'h00
`define CCP_RST_PERIOD 8'hff

// Prescale factors for timebase settings 0 and 1
`define CCP_PRE_1 2'h0
`define CCP_PRE_4 2'h1

// Quarter cycles per instruction cycle
`define CCP_QCLK_PER_TICK 3'h4

`endif

// ---- verilog/ccp_pkg.sv ----
package ccp_pkg;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_COMPARE,
    MODE_PWM
  } unit_mode_e;

  typedef struct packed {
    logic adc_start;
    logic sw_irq;
    logic tb_clear;
  } cmp_event_s;

  typedef struct packed {
    logic [7:0] period;
    logic [1:0] prescale;
    logic run;
  } tb_cfg_s;

endpackage

// ---- verilog/pwm_timebase.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ccp_regs.svh"

module pwm_timebase
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire ccp_pkg::tb_cfg_s cfg_i,
  output logic [7:0] count_o,
  output logic [1:0] fine_o,
  output logic tick_o,
  output logic roll_o
);

  logic [1:0] qclk_r;
  logic [3:0] pre_r;
  logic [7:0] count_r;
  logic [1:0] fine_nxt;
  logic tick_nxt;

  // Instruction cycle is four quarter-cycle clocks
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || !cfg_i.run)
      qclk_r <= 2'h0;
    else
      qclk_r <= qclk_r + 2'h1;
  end

  always_comb
  begin
    tick_nxt = 1'b0;
    fine_nxt = qclk_r;
    if (qclk_r == 2'h3)
    begin
      case (cfg_i.prescale)
        `CCP_PRE_1: tick_nxt = 1'b1;
        `CCP_PRE_4: tick_nxt = (pre_r[1:0] == 2'h3);
        default: tick_nxt = (pre_r == 4'hf);
      endcase
    end
    case (cfg_i.prescale)
      `CCP_PRE_1: fine_nxt = qclk_r;
      `CCP_PRE_4: fine_nxt = pre_r[1:0];
      default: fine_nxt = pre_r[3:2];
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || !cfg_i.run)
      pre_r <= 4'h0;
    else if (qclk_r == 2'h3)
      pre_r <= pre_r + 4'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      count_r <= 8'h00;
    else if (tick_nxt)
      count_r <= (count_r == cfg_i.period) ? 8'h00 : count_r + 8'h01;
  end

  assign count_o = count_r;
  assign fine_o = fine_nxt;
  assign tick_o = tick_nxt;
  assign roll_o = tick_nxt && (count_r == cfg_i.period);

endmodule
`default_nettype wire

// ---- verilog/compare_trigger_and_pwm_unit.sv ----
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ccp_regs.svh"

module compare_trigger_and_pwm_unit
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic adc_enabled_i,
  output logic unit_output_pin_o,
  output logic unit_output_pin_oe_o,
  output logic unit_irq_o,
  output ccp_pkg::cmp_event_s cmp_event_o,
  output logic postscale_event_o
);

  logic [7:0] duty_low_r;
  logic [7:0] duty_high_r;
  logic [7:0] control_r;
  logic [7:0] period_r;
  logic [6:0] tb_ctrl_r;
  logic [2:0] cmp_ctrl_r;
  logic [15:0] cmp_count_r;
  logic [1:0] duty_latch_r;
  logic irq_flag_r;
  logic post_flag_r;
  logic pin_r;
  logic roll_q_r;
  logic [3:0] post_cnt_r;
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] rdata_r;
  ccp_pkg::cmp_event_s evt_r;
  ccp_pkg::tb_cfg_s tb_cfg;
  ccp_pkg::unit_mode_e mode;
  logic [7:0] tb_count;
  logic [1:0] tb_fine;
  logic tb_tick;
  logic tb_roll;
  logic [9:0] duty_prog;
  logic [9:0] duty_active;
  logic [15:0] cmp_value;
  logic cmp_match;
  logic cmp_edge_r;
  logic addr_ok;
  logic wr_req;
  logic rd_req;
  logic postscale_hit;

  function automatic ccp_pkg::unit_mode_e decode_mode(input logic [3:0] m);
    if (m[3:2] == 2'b11)
      decode_mode = ccp_pkg::MODE_PWM;
    else if (m == 4'h0)
      decode_mode = ccp_pkg::MODE_OFF;
    else
      decode_mode = ccp_pkg::MODE_COMPARE;
  endfunction

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == `CCP_OFF_DUTY_LOW) || (a == `CCP_OFF_DUTY_HIGH) ||
      (a == `CCP_OFF_CONTROL) || (a == `CCP_OFF_PERIOD) ||
      (a == `CCP_OFF_TB_CTRL) || (a == `CCP_OFF_CMP_CTRL) ||
      (a == `CCP_OFF_STATUS) || (a == `CCP_OFF_CMP_COUNT);
  endfunction

  assign mode = decode_mode(control_r[3:0]);
  // duty from low register and control 5:4
  assign duty_prog = {duty_low_r, control_r[5:4]};
  // high register plus hidden 2-bit latch
  assign duty_active = {duty_high_r, duty_latch_r};
  assign cmp_value = {duty_high_r, duty_low_r};

  // Single-cycle slave: no wait states are ever inserted
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_req = addr_ok && hwrite;
  assign rd_req = addr_ok && !hwrite;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end
    else
    begin
      wr_pend_r <= wr_req && is_reg(haddr);
      wr_addr_r <= haddr;
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      rdata_r <= 32'h0000_0000;
    else if (rd_req)
    begin
      case (haddr)
        `CCP_OFF_DUTY_LOW: rdata_r <= {24'h000000, duty_low_r};
        `CCP_OFF_DUTY_HIGH: rdata_r <= {24'h000000, duty_high_r};
        `CCP_OFF_CONTROL: rdata_r <= {24'h000000, 2'b00, control_r[5:0]};
        `CCP_OFF_PERIOD: rdata_r <= {24'h000000, period_r};
        `CCP_OFF_TB_CTRL: rdata_r <= {25'h0000000, tb_ctrl_r};
        `CCP_OFF_CMP_CTRL: rdata_r <= {29'h00000000, cmp_ctrl_r};
        `CCP_OFF_STATUS:
          rdata_r <= {tb_count, 22'h0, post_flag_r, irq_flag_r};
        `CCP_OFF_CMP_COUNT: rdata_r <= {16'h0000, cmp_count_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rdata_r;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      duty_low_r <= `CCP_RST_BYTE;
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_DUTY_LOW)
      duty_low_r <= hwdata[7:0];
  end

  // duty bits writable at any time
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      control_r <= `CCP_RST_BYTE;
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_CONTROL)
      control_r <= {2'b00, hwdata[5:0]};
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      period_r <= `CCP_RST_PERIOD;
      tb_ctrl_r <= 7'h00;
      cmp_ctrl_r <= 3'h0;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `CCP_OFF_PERIOD)
        period_r <= hwdata[7:0];
      if (wr_addr_r == `CCP_OFF_TB_CTRL)
        tb_ctrl_r <= hwdata[6:0];
      if (wr_addr_r == `CCP_OFF_CMP_CTRL)
        cmp_ctrl_r <= hwdata[2:0];
    end
  end

  // prescale setting 3 acts as 16
  assign tb_cfg = '{period: period_r,
    prescale: tb_ctrl_r[`CCP_TB_PRE_LSB +: 2],
    run: tb_ctrl_r[`CCP_TB_ON_BIT]};

  // period (period+1) ticks of 4 qclk times prescale
  pwm_timebase u_timebase
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .cfg_i(tb_cfg),
    .count_o(tb_count),
    .fine_o(tb_fine),
    .tick_o(tb_tick),
    .roll_o(tb_roll)
  );

  // high register read-only while in PWM mode
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      duty_high_r <= `CCP_RST_BYTE;
      duty_latch_r <= 2'b00;
    end
    else if (mode == ccp_pkg::MODE_PWM)
    begin
      if (tb_roll)
      begin
        duty_high_r <= duty_prog[9:2];
        duty_latch_r <= duty_prog[1:0];
      end
    end
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_DUTY_HIGH)
      duty_high_r <= hwdata[7:0];
  end

  // Set and clear both lag the timebase one clock, so high time is exact
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      roll_q_r <= 1'b0;
    else
      roll_q_r <= tb_roll;
  end

  // PWM pin logic
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      pin_r <= 1'b0;
    else
    begin
      case (mode)
        ccp_pkg::MODE_PWM:
        begin
          // set after rollover unless zero duty
          if (roll_q_r)
            pin_r <= (duty_active != 10'h000);
          // clear on fine-extended match; high time follows
          // long duty never matches, stays high
          else if (duty_active == {tb_count, tb_fine})
            pin_r <= 1'b0;
        end
        // compare modes here leave the pin unchanged
        ccp_pkg::MODE_COMPARE: pin_r <= pin_r;
        default: pin_r <= 1'b0;
      endcase
    end
  end
  assign unit_output_pin_o = pin_r;
  assign unit_output_pin_oe_o = (mode == ccp_pkg::MODE_PWM);

  // match every cycle against compare timebase
  assign cmp_match = (mode == ccp_pkg::MODE_COMPARE) &&
    (cmp_count_r == cmp_value);

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      cmp_count_r <= 16'h0000;
    else if (evt_r.tb_clear)
      cmp_count_r <= 16'h0000;
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_CMP_COUNT)
      cmp_count_r <= hwdata[15:0];
    else if (cmp_ctrl_r[`CCP_CMP_ON_BIT])
      cmp_count_r <= cmp_count_r + 16'h0001;
  end

  // Edge of match, so a stalled count gives one event only
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      cmp_edge_r <= 1'b0;
    else
      cmp_edge_r <= cmp_match;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      evt_r <= '0;
    else
    begin
      evt_r.sw_irq <= cmp_match && !cmp_edge_r &&
        (control_r[3:0] == `CCP_MODE_SWINT);
      evt_r.tb_clear <= cmp_match && !cmp_edge_r &&
        (control_r[3:0] == `CCP_MODE_SPECIAL);
      evt_r.adc_start <= cmp_match && !cmp_edge_r &&
        (control_r[3:0] == `CCP_MODE_SPECIAL) && adc_enabled_i &&
        cmp_ctrl_r[`CCP_ADC_EN_BIT];
    end
  end
  assign cmp_event_o = evt_r;

  // flag set by any compare match; set wins over clear
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      irq_flag_r <= 1'b0;
    else if (cmp_match && !cmp_edge_r)
      irq_flag_r <= 1'b1;
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_STATUS &&
      hwdata[`CCP_ST_IRQ_BIT])
      irq_flag_r <= 1'b0;
  end
  assign unit_irq_o = irq_flag_r && cmp_ctrl_r[`CCP_IRQ_EN_BIT];

  // postscaler counts rollovers, never the period
  assign postscale_hit = tb_roll &&
    (post_cnt_r == tb_ctrl_r[`CCP_TB_POST_LSB +: 4]);
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      post_cnt_r <= 4'h0;
    // Control write restarts the count so a lower setting applies at once
    else if (postscale_hit ||
      (wr_pend_r && wr_addr_r == `CCP_OFF_TB_CTRL))
      post_cnt_r <= 4'h0;
    else if (tb_roll)
      post_cnt_r <= post_cnt_r + 4'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      post_flag_r <= 1'b0;
    else if (postscale_hit)
      post_flag_r <= 1'b1;
    else if (wr_pend_r && wr_addr_r == `CCP_OFF_STATUS &&
      hwdata[`CCP_ST_POST_BIT])
      post_flag_r <= 1'b0;
  end
  assign postscale_event_o = postscale_hit;

  logic unused_ok;
  assign unused_ok = ^{hsize, tb_tick, htrans[0]};

endmodule
`default_nettype wire

// ---- tb/adc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_model
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic en_req_i,
  input wire logic start_i,
  output logic enabled_o,
  output logic [15:0] starts_o
);
  // enable ahead
  // Registered, so a late enable misses the match in flight
  always_ff @(posedge clock_i)
  begin
    enabled_o <= !sys_rst_i && en_req_i;
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      starts_o <= 16'h0000;
    else if (start_i)
      starts_o <= starts_o + 16'h0001;
  end
endmodule
`default_nettype wire

// ---- tb/ccp_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccp_props
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic adc_enabled_i,
  input wire logic unit_output_pin_o,
  input wire logic unit_output_pin_oe_o,
  input wire ccp_pkg::cmp_event_s cmp_event_o,
  input wire logic postscale_event_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence trig_s;
    cmp_event_o.adc_start && cmp_event_o.tb_clear;
  endsequence
  sequence gone_s;
    cmp_event_o == 3'h0;
  endsequence
  event_pulse_a: assert property (
    cmp_event_o != 3'h0 |=> gone_s) else $error("event too long");
  adc_trig_a: assert property (
    cmp_event_o.adc_start |-> trig_s) else $error("start alone");
  adc_gate_a: assert property (
    cmp_event_o.adc_start |-> $past(adc_enabled_i)) else $error("adc off");
  trig_mode_a: assert property (
    cmp_event_o.tb_clear |-> !unit_output_pin_oe_o) else $error("pwm trig");
  pin_kept_a: assert property (
    cmp_event_o.sw_irq |-> $stable(unit_output_pin_o)
    && !unit_output_pin_oe_o) else $error("pin touched");
  post_pulse_a: assert property (
    postscale_event_o |=> !postscale_event_o) else $error("post too long");
  rd_hold_a: assert property (
    !$past(hsel && hready && htrans == 2'h2 && !hwrite)
    |-> $stable(hrdata)) else $error("read data moved");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus error");
  reset_quiet_a: assert property ($fell(sys_rst_i)
    |-> gone_s ##0 !unit_output_pin_o) else $error("busy after reset");
endmodule
bind compare_trigger_and_pwm_unit ccp_props chk_u
(
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
  .hreadyout(hreadyout), .adc_enabled_i(adc_enabled_i),
  .unit_output_pin_o(unit_output_pin_o), .cmp_event_o(cmp_event_o),
  .unit_output_pin_oe_o(unit_output_pin_oe_o),
  .postscale_event_o(postscale_event_o)
);
`default_nettype wire

// ---- tb/compare_trigger_and_pwm_unit_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module compare_trigger_and_pwm_unit_bench;
  logic clock_i, sys_rst_i, hsel, hwrite, en_req, pin_q, hreadyout, hresp;
  logic adc_en, pin, oe, irq, post;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] starts, n0;
  ccp_pkg::cmp_event_s ev;
  int n_errors, checked, run, hi_len, per_len, k, n_post, p0;
  compare_trigger_and_pwm_unit dut_u
  (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .adc_enabled_i(adc_en), .unit_output_pin_o(pin),
    .unit_output_pin_oe_o(oe), .unit_irq_o(irq), .cmp_event_o(ev),
    .postscale_event_o(post)
  );
  adc_model adc_u
  (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .en_req_i(en_req),
    .start_i(ev.adc_start), .enabled_o(adc_en), .starts_o(starts)
  );
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Length of each high run and of each rise-to-rise period
  always @(posedge clock_i)
  begin
    pin_q <= pin;
    run <= (pin && !pin_q) ? 1 : run + 1;
    if (pin && !pin_q)
      per_len <= run;
    if (!pin && pin_q)
      hi_len <= run;
    if (post === 1'b1)
      n_post <= n_post + 1;
  end
  task finish_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task rdy;
    @(posedge clock_i);
    for (k = 0; k < 50 && hreadyout !== 1'b1; k++)
      @(posedge clock_i);
    if (k == 50)
      begin
        n_errors++;
        finish_test;
      end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task wpin(input logic v);
    for (k = 0; k < 3000 && !(pin === v && pin_q === !v); k++)
      @(posedge clock_i);
    `CHK(k < 3000, 1'b1)
    @(posedge clock_i);
  endtask
  task hold(input logic v);
    bus(1'b1, 12'h010, 32'h4);
    repeat (100) @(posedge clock_i);
    p0 = n_post;
    for (k = 0; k < 200 && pin === v; k++)
      @(posedge clock_i);
    `CHK(k, 200)
    `CHK(n_post - p0, 5)
  endtask
  task t_regs;
    bus(1'b0, 12'h00c, 32'h0);
    `CHK(rd, 32'hff)
    bus(1'b1, 12'h020, 32'hff);
    bus(1'b0, 12'h020, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, 12'h008, 32'hff);
    bus(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h3f)
    $display("test regs done");
  endtask
  task t_pwm;
    bus(1'b1, 12'h00c, 32'h09);
    bus(1'b1, 12'h000, 32'h02);
    bus(1'b1, 12'h008, 32'h20);
    for (int f = 0; f < 3; f++)
    begin
      bus(1'b1, 12'h010, 32'h7c | 32'(f));
      bus(1'b1, 12'h008, 32'h2c);
      @(posedge clock_i);
      `CHK(oe, 1'b1)
      wpin(1'b1);
      wpin(1'b0);
      wpin(1'b1);
      `CHK(hi_len, 10 << (2 * f))
      `CHK(per_len, 40 << (2 * f))
    end
    wpin(1'b1);
    bus(1'b1, 12'h000, 32'h07);
    wpin(1'b0);
    `CHK(hi_len, 160)
    bus(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h02)
    bus(1'b1, 12'h004, 32'h55);
    wpin(1'b1);
    wpin(1'b0);
    `CHK(hi_len, 480)
    bus(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h07)
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h008, 32'h0c);
    hold(1'b0);
    bus(1'b1, 12'h000, 32'hff);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, 12'h008, 32'h3c | 32'(m));
      hold(1'b1);
    end
    $display("test pwm done");
  endtask
  task t_cmp;
    bus(1'b1, 12'h010, 32'h0);
    bus(1'b1, 12'h008, 32'h0a);
    bus(1'b1, 12'h004, 32'h0);
    bus(1'b1, 12'h000, 32'h30);
    bus(1'b1, 12'h01c, 32'h0);
    bus(1'b1, 12'h014, 32'h05);
    for (k = 0; k < 200 && irq !== 1'b1; k++)
      @(posedge clock_i);
    `CHK(irq, 1'b1)
    `CHK(pin, 1'b1)
    bus(1'b0, 12'h018, 32'h0);
    `CHK(rd[0], 1'b1)
    bus(1'b1, 12'h018, 32'h1);
    @(posedge clock_i);
    `CHK(irq, 1'b0)
    en_req <= 1'b1;
    bus(1'b1, 12'h008, 32'h0b);
    bus(1'b1, 12'h01c, 32'h0);
    n0 = starts;
    bus(1'b1, 12'h014, 32'h03);
    repeat (400) @(posedge clock_i);
    `CHK(starts - n0 > 16'h5, 1'b1)
    bus(1'b0, 12'h018, 32'h0);
    `CHK(rd[0], 1'b1)
    `CHK(irq, 1'b0)
    en_req <= 1'b0;
    repeat (3) @(posedge clock_i);
    n0 = starts;
    repeat (200) @(posedge clock_i);
    `CHK(starts, n0)
    $display("test compare done");
  endtask
  initial
  begin
    sys_rst_i = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    en_req = 1'b0;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_pwm;
    t_cmp;
    finish_test;
  end
endmodule
`default_nettype wire
